/* File: hdl/tpf_pkg.sv */
// Shared constants for the teletext page request filter
package tpf_pkg;
   // ==========================================
   // Register map (byte addresses)
   localparam logic [7:0] ACQ_CTRL_ADDR = 8'h00; // acquisition_control_reg
   localparam logic [7:0] REQ_PTR_ADDR = 8'h04;  // request_pointer_reg
   localparam logic [7:0] REQ_DATA_ADDR = 8'h08; // request_data_port
   localparam logic [7:0] STATUS_ADDR = 8'h0c;
   localparam int ADDR_W = 8;
   // ==========================================
   // Control fields
   localparam int CTRL_EXT_DIS_BIT = 0;          // extension_capture_disable
   localparam int CTRL_ACQ_EN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;
   // Pointer fields
   localparam int PTR_COL_LSB = 0;
   localparam int PTR_COL_W = 3;
   localparam int PTR_SLOT_LSB = 4;
   localparam int PTR_SLOT_W = 4;
   // Status fields
   localparam int ST_QUAL_BIT = 0;
   localparam int ST_525_BIT = 1;
   localparam int ST_HIT_BIT = 2;
   localparam int ST_BLOCK_LSB = 4;
   // ==========================================
   // Slot layout
   localparam int NUM_SLOTS = 10;
   localparam int COLS = 8;
   localparam int COL_W = 5;
   localparam int SLOT_W = COLS * COL_W;
   localparam int CARE_BIT = 4;                  // slot_ram_bit 4
   localparam int HOLD_BIT = 3;                  // slot_ram_bit 3
   localparam logic [3:0] MAX_SLOT = 4'h9;
   localparam logic [3:0] PAGE_SLOTS_EXT_OFF = 4'ha;
   localparam logic [3:0] PAGE_SLOTS_EXT_ON = 4'h9;
   localparam logic [COL_W-1:0] COL0_RESET = 5'h08;
   localparam logic [COL_W-1:0] COLN_RESET = 5'h00;
   // Significant digit bits per column 0..6; column 7 carries the mode
   localparam logic [COL_W-1:0] DIGIT_MASK [0:6] = '{5'h07, 5'h0f, 5'h0f, 5'h03,
                                                    5'h0f, 5'h07, 5'h0f};
   localparam logic [COL_W-1:0] MODE_MASK = 5'h03;
   // ==========================================
   // Line timing
   localparam int CLK_HZ = 20_000_000;
   localparam int LINE_625_NS = 64000;
   localparam int LINE_525_NS = 63556;
   localparam int LOCK_TOL_NS = 1000;
   localparam int LINE_625_CYC = LINE_625_NS / (1_000_000_000 / CLK_HZ);
   localparam int LINE_525_CYC = LINE_525_NS / (1_000_000_000 / CLK_HZ);
   localparam int LOCK_TOL_CYC = LOCK_TOL_NS / (1_000_000_000 / CLK_HZ);
   localparam int STD_SPLIT_CYC = (LINE_625_CYC + LINE_525_CYC) / 2;
   localparam int QUAL_LINES = 8;
   localparam int LINE_CNT_W = 12;
   // ==========================================
   // Scanner states
   typedef enum logic [1:0] {SC_IDLE, SC_FETCH, SC_CMP} tpf_scan_t;
endpackage

/* File: hdl/tpf_slot_ram.sv */
// Page request slot memory with column writes and registered slot read
`timescale 1ns/1ps
module tpf_slot_ram #(
   parameter int SLOTS = tpf_pkg::NUM_SLOTS
) (
   input wire logic clk,                              // System clock
   input wire logic rstN,                             // Synchronised reset, active low
   input wire logic wrEn,                             // Column write strobe
   input wire logic [3:0] wrSlot,                     // Slot written
   input wire logic [2:0] wrCol,                      // Column written
   input wire logic [tpf_pkg::COL_W-1:0] wrData,      // Column data
   input wire logic [3:0] rdSlot,                     // Slot read
   output logic [tpf_pkg::SLOT_W-1:0] rdData          // Registered slot contents
);
   logic [tpf_pkg::SLOT_W-1:0] mem_q [0:SLOTS-1];

   // ==========================================
   // Storage, every slot matches any page after reset
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         for (int s = 0; s < SLOTS; s++) begin
            mem_q[s] <= {{(tpf_pkg::COLS-1){tpf_pkg::COLN_RESET}}, tpf_pkg::COL0_RESET};
         end
      end else if (wrEn && (wrSlot < 4'(SLOTS))) begin
         mem_q[wrSlot][wrCol*tpf_pkg::COL_W +: tpf_pkg::COL_W] <= wrData;
      end
   end

   // ==========================================
   // Registered read port
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rdData <= '0;
      end else if (rdSlot < 4'(SLOTS)) begin
         rdData <= mem_q[rdSlot];
      end else begin
         rdData <= '0;
      end
   end
endmodule

/* File: hdl/tpf_page_filter.sv */
// Teletext page request store, header matcher and line lock detector
`timescale 1ns/1ps
// Notes on behaviour
// - Each data port write to slots 0 to 9 stores its low five bits at the pointer, then the pointer advances
// - Writing the pointer sets where later data port writes land
// - Pointer slot field chooses which of ten slots data writes modify
// - Slot values above nine make data port writes store nothing, though the column still advances
// - Ten page slots with extension capture disabled, nine otherwise
// - A digit with its compare enable low is left out of matching
// - A slot with hold low matches no page
// - Slot mode bits choose error checking for packets 1 to 23
// - A page matching several slots goes to the lowest one only
// - After reset every slot matches any page, hold on, mode zero
// - Pages are named by magazine, page and four subcode digits
// - Columns 0 to 6 carry enable, hold, magazine, page and subcode digits; column 7 the mode
// - Subcode digits sit in columns 3 to 6 at their own widths
// - Acquisition follows sync lock and stops on poor signal quality
// - Both 625-line and 525-line transmissions are locked and matched
// - Captured page goes to the block numbered as its slot
module tpf_page_filter #(
   parameter int SLOTS = tpf_pkg::NUM_SLOTS
) (
   input wire logic clk,                    // 20 MHz clock
   input wire logic resetn,                 // Asynchronous reset, active low
   input wire logic psel,                   // APB select
   input wire logic penable,                // APB access phase
   input wire logic pwrite,                 // APB direction
   input wire logic [7:0] paddr,            // APB byte address
   input wire logic [31:0] pwdata,          // APB write data
   output logic [31:0] prdata,              // APB read data
   output logic pready,                     // APB ready
   output logic pslverr,                    // APB error on unmapped address
   input wire logic composite_sync_in,      // Composite sync, positive going
   input wire logic headerStrobe,           // One cycle pulse with a page header
   input wire logic [2:0] hundreds_digit,   // Received magazine
   input wire logic [3:0] page_tens_digit,  // Received page tens
   input wire logic [3:0] page_units_digit, // Received page units
   input wire logic [1:0] hours_tens_digit, // Received hours tens
   input wire logic [3:0] hours_units_digit, // Received hours units
   input wire logic [2:0] minutes_tens_digit, // Received minutes tens
   input wire logic [3:0] minutes_units_digit, // Received minutes units
   output logic captureStrobe,              // One cycle pulse on a capture
   output logic [3:0] captureBlock,         // Memory block of the capture
   output logic check_mode_hi,              // Mode bit 1 for packets 1 to 23
   output logic check_mode_lo,              // Mode bit 0 for packets 1 to 23
   output logic acqEnabled                  // Acquisition running
);
   logic rstMeta_q, rstSync_q;
   logic [1:0] ctrl_q;
   logic [3:0] ptrSlot_q;
   logic [2:0] ptrCol_q;
   logic accessDone, wrCtrl, wrPtr, wrData, mapped;
   logic [31:0] rdValue;
   logic syncPrev_q;
   logic [tpf_pkg::LINE_CNT_W-1:0] lineCnt_q;
   logic [3:0] qualCnt_q;
   logic is525_q, lastHit_q;
   tpf_pkg::tpf_scan_t scan_q;
   logic [3:0] scanSlot_q, slotLimit;
   logic [tpf_pkg::SLOT_W-1:0] slotData;
   logic [tpf_pkg::SLOT_W-1:0] hdr_q;
   logic slotMatch;

   // ==========================================
   // Reset release through two flip-flops
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // ==========================================
   // APB decode; one wait state, write lands at the ready edge
   function automatic logic addrIs(input logic [7:0] a, input logic [7:0] ref_a);
      addrIs = (a == ref_a);
   endfunction

   assign accessDone = psel && penable && pready;
   assign mapped = addrIs(paddr, tpf_pkg::ACQ_CTRL_ADDR) || addrIs(paddr, tpf_pkg::REQ_PTR_ADDR)
                || addrIs(paddr, tpf_pkg::REQ_DATA_ADDR) || addrIs(paddr, tpf_pkg::STATUS_ADDR);
   assign wrCtrl = accessDone && pwrite && addrIs(paddr, tpf_pkg::ACQ_CTRL_ADDR);
   assign wrPtr = accessDone && pwrite && addrIs(paddr, tpf_pkg::REQ_PTR_ADDR);
   assign wrData = accessDone && pwrite && addrIs(paddr, tpf_pkg::REQ_DATA_ADDR);

   // Read mux; the data port is write only and reads zero
   always_comb begin
      rdValue = '0;
      if (addrIs(paddr, tpf_pkg::ACQ_CTRL_ADDR)) begin
         rdValue[1:0] = ctrl_q;
      end else if (addrIs(paddr, tpf_pkg::REQ_PTR_ADDR)) begin
         rdValue[tpf_pkg::PTR_COL_LSB +: tpf_pkg::PTR_COL_W] = ptrCol_q;
         rdValue[tpf_pkg::PTR_SLOT_LSB +: tpf_pkg::PTR_SLOT_W] = ptrSlot_q;
      end else if (addrIs(paddr, tpf_pkg::STATUS_ADDR)) begin
         rdValue[tpf_pkg::ST_QUAL_BIT] = acqEnabled;
         rdValue[tpf_pkg::ST_525_BIT] = is525_q;
         rdValue[tpf_pkg::ST_HIT_BIT] = lastHit_q;
         rdValue[tpf_pkg::ST_BLOCK_LSB +: 4] = captureBlock;
      end
   end

   // Bus answer registers
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         pslverr <= !mapped;
         prdata <= pwrite ? 32'h0000_0000 : rdValue;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // ==========================================
   // Control register
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         ctrl_q <= tpf_pkg::CTRL_RESET;
      end else if (wrCtrl) begin
         ctrl_q <= pwdata[1:0];
      end
   end

   // Request pointer; set by a write, advanced by each data write
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         ptrSlot_q <= 4'h0;
         ptrCol_q <= 3'h0;
      end else if (wrPtr) begin
         ptrCol_q <= pwdata[tpf_pkg::PTR_COL_LSB +: tpf_pkg::PTR_COL_W];
         ptrSlot_q <= pwdata[tpf_pkg::PTR_SLOT_LSB +: tpf_pkg::PTR_SLOT_W];
      end else if (wrData) begin
         ptrCol_q <= ptrCol_q + 3'h1;
      end
   end

   // ==========================================
   // Line lock: sync edges must fall within tolerance of a line period
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         syncPrev_q <= 1'b0;
         lineCnt_q <= '0;
         qualCnt_q <= 4'h0;
         is525_q <= 1'b0;
      end else begin
         syncPrev_q <= composite_sync_in;
         if (composite_sync_in && !syncPrev_q) begin
            lineCnt_q <= '0;
            if ((lineCnt_q >= 12'(tpf_pkg::LINE_525_CYC - tpf_pkg::LOCK_TOL_CYC))
                && (lineCnt_q <= 12'(tpf_pkg::LINE_625_CYC + tpf_pkg::LOCK_TOL_CYC))) begin
               is525_q <= (lineCnt_q < 12'(tpf_pkg::STD_SPLIT_CYC));
               if (qualCnt_q < 4'(tpf_pkg::QUAL_LINES)) begin
                  qualCnt_q <= qualCnt_q + 4'h1;
               end
            end else begin
               qualCnt_q <= 4'h0;
            end
         end else if (lineCnt_q > 12'(tpf_pkg::LINE_625_CYC + tpf_pkg::LOCK_TOL_CYC)) begin
            lineCnt_q <= '0;
            qualCnt_q <= 4'h0;
         end else begin
            lineCnt_q <= lineCnt_q + 12'h001;
         end
      end
   end

   // Acquisition gate from control and signal quality
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         acqEnabled <= 1'b0;
      end else begin
         acqEnabled <= ctrl_q[tpf_pkg::CTRL_ACQ_EN_BIT]
                       && (qualCnt_q == 4'(tpf_pkg::QUAL_LINES));
      end
   end

   // ==========================================
   // Slot memory
   tpf_slot_ram #(.SLOTS(SLOTS)) u_tpf_slot_ram (
      .clk(clk),
      .rstN(rstSync_q),
      .wrEn(wrData && (ptrSlot_q <= tpf_pkg::MAX_SLOT)),
      .wrSlot(ptrSlot_q),
      .wrCol(ptrCol_q),
      .wrData(pwdata[tpf_pkg::COL_W-1:0]),
      .rdSlot(scanSlot_q),
      .rdData(slotData)
   );

   // ==========================================
   // Header match against one slot
   assign slotLimit = ctrl_q[tpf_pkg::CTRL_EXT_DIS_BIT] ? tpf_pkg::PAGE_SLOTS_EXT_OFF
                                                        : tpf_pkg::PAGE_SLOTS_EXT_ON;
   always_comb begin
      logic [tpf_pkg::COL_W-1:0] col, hcol;
      col = '0;
      hcol = '0;
      slotMatch = slotData[tpf_pkg::HOLD_BIT];
      for (int c = 0; c < tpf_pkg::COLS - 1; c++) begin
         col = slotData[c*tpf_pkg::COL_W +: tpf_pkg::COL_W];
         hcol = hdr_q[c*tpf_pkg::COL_W +: tpf_pkg::COL_W];
         if (col[tpf_pkg::CARE_BIT] && ((col & tpf_pkg::DIGIT_MASK[c])
             != (hcol & tpf_pkg::DIGIT_MASK[c]))) begin
            slotMatch = 1'b0;
         end
      end
   end

   // Scan slots in ascending order, first hit wins
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         scan_q <= tpf_pkg::SC_IDLE;
         scanSlot_q <= 4'h0;
         hdr_q <= '0;
      end else begin
         case (scan_q)
            tpf_pkg::SC_IDLE: begin
               if (headerStrobe && acqEnabled) begin
                  // Pack as slot columns 0..6: magazine, page, subcode
                  hdr_q <= {5'h00, 1'b0, minutes_units_digit, 2'h0, minutes_tens_digit,
                            1'b0, hours_units_digit, 3'h0, hours_tens_digit,
                            1'b0, page_units_digit, 1'b0, page_tens_digit,
                            2'h0, hundreds_digit};
                  scanSlot_q <= 4'h0;
                  scan_q <= tpf_pkg::SC_FETCH;
               end
            end
            tpf_pkg::SC_FETCH: begin
               scan_q <= tpf_pkg::SC_CMP;
            end
            tpf_pkg::SC_CMP: begin
               if (slotMatch || (scanSlot_q + 4'h1 >= slotLimit)) begin
                  scan_q <= tpf_pkg::SC_IDLE;
               end else begin
                  scanSlot_q <= scanSlot_q + 4'h1;
                  scan_q <= tpf_pkg::SC_FETCH;
               end
            end
            default: begin
               scan_q <= tpf_pkg::SC_IDLE;
            end
         endcase
      end
   end

   // Capture result towards the page memory writer
   always_ff @(posedge clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         captureStrobe <= 1'b0;
         captureBlock <= 4'h0;
         check_mode_hi <= 1'b0;
         check_mode_lo <= 1'b0;
         lastHit_q <= 1'b0;
      end else begin
         captureStrobe <= 1'b0;
         if ((scan_q == tpf_pkg::SC_CMP) && slotMatch) begin
            captureStrobe <= 1'b1;
            captureBlock <= scanSlot_q;
            check_mode_hi <= slotData[(tpf_pkg::COLS-1)*tpf_pkg::COL_W + 1];
            check_mode_lo <= slotData[(tpf_pkg::COLS-1)*tpf_pkg::COL_W];
            lastHit_q <= 1'b1;
         end else if ((scan_q == tpf_pkg::SC_IDLE) && headerStrobe && acqEnabled) begin
            lastHit_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstSync_q);

   sequence scanStart_s;
      (scan_q == tpf_pkg::SC_IDLE) && headerStrobe && acqEnabled;
   endsequence

   scan_bound_a: assert property (scanStart_s |-> ##[1:21] (scan_q == tpf_pkg::SC_IDLE))
      else $error("slot scan did not finish");
   gated_acq_a: assert property (!acqEnabled && (scan_q == tpf_pkg::SC_IDLE)
         |=> (scan_q == tpf_pkg::SC_IDLE))
      else $error("scan started without acquisition");
   ptr_advance_a: assert property (wrData && !wrPtr |=> ptrCol_q == $past(ptrCol_q) + 3'h1)
      else $error("pointer did not advance");
   ptr_load_a: assert property (wrPtr |=> ptrSlot_q == $past(pwdata[7:4]))
      else $error("pointer slot not loaded");
   slot_limit_a: assert property (captureStrobe |-> captureBlock < $past(slotLimit))
      else $error("capture into reserved block");
   hold_gate_a: assert property ((scan_q == tpf_pkg::SC_CMP) && !slotData[tpf_pkg::HOLD_BIT]
         |=> !captureStrobe)
      else $error("capture with hold low");
   block_slot_a: assert property ((scan_q == tpf_pkg::SC_CMP) && slotMatch
         |=> captureStrobe && captureBlock == $past(scanSlot_q))
      else $error("block differs from slot");
   one_capture_a: assert property (captureStrobe |=> !captureStrobe)
      else $error("packet stored twice");
   lost_lock_a: assert property ($fell(qualCnt_q == 4'(tpf_pkg::QUAL_LINES))
         |=> !acqEnabled)
      else $error("acquisition kept after lock loss");
   apb_ready_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
      else $error("ready not a single wait state");
endmodule

/* File: verif/tpf_slicer_model.sv */
// Behavioural data slicer: composite sync source and page header strobes
`timescale 1ns/1ps
module tpf_slicer_model (
   input wire logic clk,              // System clock
   input wire logic run,              // Sync pulses run while high
   input wire logic [11:0] period,    // Line period in cycles
   output logic composite_sync_in,    // Positive going composite sync
   output logic headerStrobe,         // One cycle header pulse
   output logic [23:0] hdr            // Packed header digits
);
   logic [11:0] cnt_q;
   initial begin
      cnt_q = 12'h000;
      composite_sync_in = 1'b0;
      headerStrobe = 1'b0;
      hdr = 24'h000000;
   end
   // ==========================================
   // Line sync: one pulse each period, low when stopped
   always @(posedge clk) begin
      if (!run) begin
         cnt_q <= 12'h000;
         composite_sync_in <= 1'b0;
      end else begin
         cnt_q <= (cnt_q >= period - 12'h001) ? 12'h000 : cnt_q + 12'h001;
         composite_sync_in <= (cnt_q < 12'h05a);
      end
   end
   // Header pulse; digits go to the inverse once the strobe is over
   task automatic send(input logic [23:0] h);
      @(posedge clk);
      headerStrobe <= 1'b1;
      hdr <= h;
      @(posedge clk);
      headerStrobe <= 1'b0;
      hdr <= ~h;
   endtask
endmodule

/* File: verif/test_tpf_page_filter.sv */
// Self-checking bench of the page request filter over APB
`timescale 1ns/1ps
`define CHK(g, e) chk((g), (e))
module test_tpf_page_filter;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, composite_sync_in, headerStrobe;
   logic captureStrobe, check_mode_hi, check_mode_lo, acqEnabled;
   logic [3:0] captureBlock;
   logic [23:0] hdr;
   logic run = 1'b0;
   logic [11:0] period = 12'h500;
   logic [31:0] rd;
   logic err;
   int error_cnt = 0;
   int cmp_count = 0;
   // Header packs magazine 1, page 23, subcode 1 5 : 2 9
   localparam logic [23:0] H1 = {3'h1, 4'h2, 4'h3, 2'h1, 4'h5, 3'h2, 4'h9};
   localparam logic [23:0] H7 = {3'h1, 4'h7, 4'h3, 2'h1, 4'h5, 3'h2, 4'h9};
   always #25 clk = ~clk;
   tpf_page_filter u_tpf_page_filter (.clk(clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .composite_sync_in(composite_sync_in), .headerStrobe(headerStrobe),
      .hundreds_digit(hdr[23:21]), .page_tens_digit(hdr[20:17]),
      .page_units_digit(hdr[16:13]), .hours_tens_digit(hdr[12:11]),
      .hours_units_digit(hdr[10:7]), .minutes_tens_digit(hdr[6:4]),
      .minutes_units_digit(hdr[3:0]), .captureStrobe(captureStrobe),
      .captureBlock(captureBlock), .check_mode_hi(check_mode_hi),
      .check_mode_lo(check_mode_lo), .acqEnabled(acqEnabled));
   tpf_slicer_model u_tpf_slicer_model (.clk(clk), .run(run), .period(period),
      .composite_sync_in(composite_sync_in), .headerStrobe(headerStrobe), .hdr(hdr));
   // ==========================================
   // Verdict and comparison
   task automatic results();
      if (error_cnt == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // APB transfer: setup, access until pready, release after that edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 20; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 20) begin
         error_cnt++;
         results();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // Program one slot; hold dropped first, set last; don't-care bits written as ones
   task automatic slot(input logic [3:0] k, input logic [23:0] h, input logic [6:0] c,
                       input logic hold, input logic [1:0] mode);
      logic [4:0] col [0:7];
      col[0] = {c[0], hold, h[23:21]};
      col[1] = {c[1], h[20:17]};
      col[2] = {c[2], h[16:13]};
      col[3] = {c[3], 2'h3, h[12:11]};
      col[4] = {c[4], h[10:7]};
      col[5] = {c[5], 1'b1, h[6:4]};
      col[6] = {c[6], h[3:0]};
      col[7] = {3'h7, mode};
      apb(1'b1, tpf_pkg::REQ_PTR_ADDR, {24'h0, k, 4'h0});
      apb(1'b1, tpf_pkg::REQ_DATA_ADDR, {27'h0, col[0] & 5'h17});
      for (int i = 1; i < 9; i++) apb(1'b1, tpf_pkg::REQ_DATA_ADDR, {27'h0, col[i % 8]});
   endtask
   // Send a header and look for one capture within the scan window
   task automatic hdrChk(input logic [23:0] h, input logic hit, input logic [3:0] blk,
                         input logic [1:0] mode);
      logic seen;
      seen = 1'b0;
      u_tpf_slicer_model.send(h);
      for (int n = 0; n < 30; n++) begin
         @(posedge clk);
         if (captureStrobe === 1'b1 && !seen) begin
            seen = 1'b1;
            `CHK(captureBlock, blk);
            `CHK({check_mode_hi, check_mode_lo}, mode);
         end
      end
      `CHK(seen, hit);
   endtask
   task automatic waitAcq(input logic lvl, input int lim);
      int n;
      for (n = 0; n < lim; n++) begin
         @(posedge clk);
         if (acqEnabled === lvl) break;
      end
      if (n == lim) begin
         error_cnt++;
         results();
      end
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, tpf_pkg::ACQ_CTRL_ADDR, 32'h0);
      `CHK(rd, 32'h2);
      apb(1'b0, 8'h10, 32'h0);
      `CHK(err, 1'b1);
      run <= 1'b1;
      waitAcq(1'b1, 20000);
      apb(1'b0, tpf_pkg::STATUS_ADDR, 32'h0);
      `CHK(rd[7:0], 8'h01);
      hdrChk(H1, 1'b1, 4'h0, 2'h0);
      for (int k = 0; k < 9; k++) slot(k[3:0], 24'h0, 7'h00, 1'b0, 2'h0);
      hdrChk(H1, 1'b0, 4'h0, 2'h0);
      apb(1'b1, tpf_pkg::ACQ_CTRL_ADDR, 32'h3);
      slot(4'h9, H1, 7'h7f, 1'b1, 2'h3);
      hdrChk(H1, 1'b1, 4'h9, 2'h3);
      hdrChk(H1 ^ 24'h002000, 1'b0, 4'h0, 2'h0);
      hdrChk(H1 ^ 24'h000800, 1'b0, 4'h0, 2'h0);
      slot(4'h5, H1, 7'h07, 1'b1, 2'h1);
      hdrChk(H1 ^ 24'h001fff, 1'b1, 4'h5, 2'h1);
      hdrChk(H1, 1'b1, 4'h5, 2'h1);
      apb(1'b1, tpf_pkg::REQ_PTR_ADDR, 32'h51);
      apb(1'b1, tpf_pkg::REQ_DATA_ADDR, 32'h17);
      apb(1'b0, tpf_pkg::REQ_PTR_ADDR, 32'h0);
      `CHK(rd, 32'h52);
      hdrChk(H1, 1'b1, 4'h9, 2'h3);
      hdrChk(H7, 1'b1, 4'h5, 2'h1);
      apb(1'b1, tpf_pkg::REQ_PTR_ADDR, 32'ha0);
      apb(1'b1, tpf_pkg::REQ_DATA_ADDR, 32'h08);
      apb(1'b1, tpf_pkg::REQ_PTR_ADDR, 32'hf0);
      apb(1'b1, tpf_pkg::REQ_DATA_ADDR, 32'h08);
      hdrChk(H1, 1'b1, 4'h9, 2'h3);
      apb(1'b1, tpf_pkg::ACQ_CTRL_ADDR, 32'h2);
      hdrChk(H1, 1'b0, 4'h0, 2'h0);
      apb(1'b1, tpf_pkg::ACQ_CTRL_ADDR, 32'h0);
      apb(1'b0, tpf_pkg::STATUS_ADDR, 32'h0);
      `CHK(rd[7:0], 8'h90);
      hdrChk(H7, 1'b0, 4'h0, 2'h0);
      apb(1'b1, tpf_pkg::ACQ_CTRL_ADDR, 32'h2);
      period <= 12'h4ec;
      repeat (12000) @(posedge clk);
      apb(1'b0, tpf_pkg::STATUS_ADDR, 32'h0);
      `CHK(rd[7:0], 8'h93);
      hdrChk(H7, 1'b1, 4'h5, 2'h1);
      run <= 1'b0;
      waitAcq(1'b0, 1500);
      hdrChk(H7, 1'b0, 4'h0, 2'h0);
      results();
   end
endmodule
